/* dpi_mem.sv */
// Purpose: storage for SDRAM timing and training words
// Assumes: one write or one read per cycle
// Notes: read data is registered
`timescale 1ns/100ps
module dpi_mem #(
  parameter int DW = 32,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] next_rd_data;

  always_comb begin
    next_rd_data = rd_data;
    if (rd_en) begin
      next_rd_data = mem[addr];
    end
  end

  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (ce) begin
      rd_data <= next_rd_data;
    end
  end
endmodule // dpi_mem

/* dpi_pkg.sv */
// Purpose: constants for the DDR PHY / controller start-up sequencer
// Assumes: 32-bit register port, 200 MHz clock
// Notes: offsets are byte addresses
package dpi_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_RST_CTRL = 12'h000;
  localparam logic [11:0] OFS_PHY_CMD = 12'h004;
  localparam logic [11:0] OFS_PHY_STAT = 12'h008;
  localparam logic [11:0] OFS_PLL_TIM0 = 12'h00c;
  localparam logic [11:0] OFS_PLL_TIM1 = 12'h010;
  localparam logic [11:0] OFS_PHY_CFG = 12'h014;
  localparam logic [11:0] OFS_SW_CTRL = 12'h018;
  localparam logic [11:0] OFS_SW_STAT = 12'h01c;
  localparam logic [11:0] OFS_DFI_MISC = 12'h020;
  localparam logic [11:0] OFS_CTRL_STAT = 12'h024;
  localparam logic [11:0] OFS_DINIT_TIM = 12'h028;
  localparam logic [11:0] OFS_REFRESH = 12'h02c;
  localparam logic [11:0] OFS_TRAIN_BASE = 12'h100;
  localparam int TRAIN_WORDS = 16;
  localparam int TRAIN_AW = 4;

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int CMD_INIT = 0;
  localparam int CMD_PLL = 1;
  localparam int CMD_ZCAL = 4;
  localparam int CMD_DCAL = 5;
  localparam int CMD_PHYRST = 6;
  localparam int CMD_CONTROLLER_DOES_DRAM_INIT = 18;
  localparam logic [31:0] CMD_FULL_START = 32'h0000_0073;

  // ----------------------------------------------------------------
  // status / config fields
  // ----------------------------------------------------------------
  localparam int STAT_DONE = 0;
  localparam int STAT_PLL_DONE = 1;
  localparam int STAT_ZCAL_DONE = 2;
  localparam int STAT_DCAL_DONE = 3;
  localparam int STAT_PHY_RST = 4;
  localparam int CFG_IO_DDR_MODE_SEL_LSB = 0;
  localparam int CFG_ZWAIT_LSB = 4;
  localparam int CFG_DTYPE_LSB = 8;
  localparam int CFG_ALL_RANK_SCHEDULE = 12;
  localparam logic [1:0] IO_DDR_MODE_SEL_RST = 2'h0;
  localparam logic [3:0] ZWAIT_RST = 4'h0;
  localparam logic [2:0] DTYPE_RST = 3'h0;
  localparam logic [2:0] OPMODE_INIT = 3'h0;
  localparam logic [2:0] OPMODE_NORMAL = 3'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DCAL_TIME_NS = 1000;
  localparam int DCAL_CYCLES = (DCAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
  localparam int ZCAL_BASE_CYCLES = 64;
  localparam int ZCAL_STEP_SHIFT = 4;
  localparam int TIM_W = 20;

  typedef enum logic [3:0] {
    CS_RESET = 4'b0001,
    CS_CONFIG = 4'b0010,
    CS_DRAM_INIT = 4'b0100,
    CS_NORMAL = 4'b1000
  } dpi_ctrl_state_t;
endpackage

/* dpi_sdram_model.sv */
// Purpose: memory side that accepts traffic once brought up
// Assumes: port reset and normal mode are levels
// Notes: ready never falls until reset
`timescale 1ns/100ps
module dpi_sdram_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic axi_rst_n_out,
  input wire logic ctrl_normal,
  output logic ready
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ready <= 1'b0;
    else if (ctrl_normal && axi_rst_n_out)
      ready <= 1'b1;
  end
endmodule // dpi_sdram_model

/* dpi_seq.sv */
// Purpose: DDR PHY bring-up and controller start-up sequencer
// Assumes: software drives every step over the register port
// Notes: timing/training words stay writable during PHY init
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
module dpi_seq
  import dpi_pkg::*;
#(
  parameter int DCAL_COUNT = DCAL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic core_rst_n_out,
  output logic axi_rst_n_out,
  output logic phy_rst_active,
  output logic phy_init_done_flag,
  output logic dfi_init_complete,
  output logic ctrl_normal
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic core_rel, axi_rel, next_core_rel, next_axi_rel;
  logic [15:0] pll_powerdown_time, next_pll_powerdown_time;
  logic [15:0] pll_gearshift_time, next_pll_gearshift_time;
  logic [15:0] pll_lock_time, next_pll_lock_time;
  logic [15:0] pll_reset_time, next_pll_reset_time;
  logic [1:0] io_ddr_mode_sel, next_io_ddr_mode_sel;
  logic [3:0] impedance_cal_wait, next_impedance_cal_wait;
  logic [2:0] dram_type_select, next_dram_type_select;
  logic all_rank_schedule, next_all_rank_schedule;
  logic [19:0] dram_init_timer_first, next_dram_init_timer_first;
  logic [17:0] phy_refresh_period, next_phy_refresh_period;
  logic software_config_done, next_software_config_done;
  logic software_config_done_ack, next_software_config_done_ack;
  logic init_cmpl_en, next_init_cmpl_en;
  logic controller_does_dram_init, next_controller_does_dram_init;
  logic pll_req, zcal_req, dcal_req;
  logic next_pll_req, next_zcal_req, next_dcal_req;
  logic pll_done, zcal_done, dcal_done;
  logic next_pll_done, next_zcal_done, next_dcal_done;
  logic next_phy_rst_active, next_phy_init_done_flag;
  logic next_dfi_init_complete, next_ctrl_normal;
  logic next_core_rst_n_out, next_axi_rst_n_out;
  logic [2:0] op_mode, next_op_mode;
  dpi_ctrl_state_t cstate, next_cstate;
  logic [31:0] reg_rdata, next_reg_rdata;
  logic mem_sel, next_mem_sel;
  logic [31:0] mem_rdata;
  logic pll_load, zcal_load, dcal_load, dram_load;
  logic [TIM_W-1:0] pll_val, zcal_val, dcal_val;
  logic pll_busy, zcal_busy, dcal_busy, dram_busy;
  logic pll_fin, zcal_fin, dcal_fin, dram_fin;
  logic wr_cmd, train_hit;

  function automatic logic is_wr(input logic [11:0] ofs);
    is_wr = wr_en && (addr == ofs);
  endfunction

  assign wr_cmd = wr_en && (addr == OFS_PHY_CMD);
  assign train_hit = addr[11:8] == OFS_TRAIN_BASE[11:8] &&
                     addr[7:TRAIN_AW+2] == '0;

  // ----------------------------------------------------------------
  // phase timers
  // ----------------------------------------------------------------
  assign pll_val = TIM_W'({1'b0, pll_reset_time} + {1'b0, pll_lock_time});
  assign zcal_val = TIM_W'(ZCAL_BASE_CYCLES) +
                    TIM_W'({impedance_cal_wait, ZCAL_STEP_SHIFT'(0)});
  assign dcal_val = TIM_W'(DCAL_COUNT);
  assign pll_load = wr_cmd && wr_data[CMD_PLL];
  assign zcal_load = wr_cmd && wr_data[CMD_ZCAL];
  assign dcal_load = (wr_cmd && wr_data[CMD_DCAL] && !wr_data[CMD_PLL]) ||
                     (pll_fin && dcal_req);

  dpi_timer #(.W(TIM_W)) u_pll_tim (
    .clk(clk), .rst_n(rst_n), .ce(ce), .load(pll_load),
    .load_val(pll_val), .busy(pll_busy), .done(pll_fin)
  );
  dpi_timer #(.W(TIM_W)) u_zcal_tim (
    .clk(clk), .rst_n(rst_n), .ce(ce), .load(zcal_load),
    .load_val(zcal_val), .busy(zcal_busy), .done(zcal_fin)
  );
  dpi_timer #(.W(TIM_W)) u_dcal_tim (
    .clk(clk), .rst_n(rst_n), .ce(ce), .load(dcal_load),
    .load_val(dcal_val), .busy(dcal_busy), .done(dcal_fin)
  );
  dpi_timer #(.W(TIM_W)) u_dram_tim (
    .clk(clk), .rst_n(rst_n), .ce(ce), .load(dram_load),
    .load_val(dram_init_timer_first), .busy(dram_busy), .done(dram_fin)
  );

  // timing and training words, writable at any time
  dpi_mem #(.DW(32), .AW(TRAIN_AW)) u_train_mem (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .wr_en(wr_en && train_hit),
    .rd_en(rd_en && train_hit),
    .addr(addr[TRAIN_AW+1:2]), .wr_data(wr_data), .rd_data(mem_rdata)
  );

  // ----------------------------------------------------------------
  // register writes and PHY init tracking
  // ----------------------------------------------------------------
  always_comb begin
    next_core_rel = core_rel;
    next_axi_rel = axi_rel;
    next_pll_powerdown_time = pll_powerdown_time;
    next_pll_gearshift_time = pll_gearshift_time;
    next_pll_lock_time = pll_lock_time;
    next_pll_reset_time = pll_reset_time;
    next_io_ddr_mode_sel = io_ddr_mode_sel;
    next_impedance_cal_wait = impedance_cal_wait;
    next_dram_type_select = dram_type_select;
    next_all_rank_schedule = all_rank_schedule;
    next_dram_init_timer_first = dram_init_timer_first;
    next_phy_refresh_period = phy_refresh_period;
    next_software_config_done = software_config_done;
    next_software_config_done_ack = software_config_done_ack;
    next_init_cmpl_en = init_cmpl_en;
    next_controller_does_dram_init = controller_does_dram_init;
    next_pll_req = pll_req;
    next_zcal_req = zcal_req;
    next_dcal_req = dcal_req;
    next_pll_done = pll_done || pll_fin;
    next_zcal_done = zcal_done || zcal_fin;
    next_dcal_done = dcal_done || dcal_fin;
    next_phy_rst_active = phy_rst_active;
    if (is_wr(OFS_RST_CTRL)) begin
      next_core_rel = wr_data[0];
      next_axi_rel = wr_data[1];
    end
    if (is_wr(OFS_PLL_TIM0)) begin
      next_pll_powerdown_time = wr_data[15:0];
      next_pll_gearshift_time = wr_data[31:16];
    end
    if (is_wr(OFS_PLL_TIM1)) begin
      next_pll_lock_time = wr_data[15:0];
      next_pll_reset_time = wr_data[31:16];
    end
    if (is_wr(OFS_PHY_CFG)) begin
      next_io_ddr_mode_sel = wr_data[CFG_IO_DDR_MODE_SEL_LSB +: 2];
      next_impedance_cal_wait = wr_data[CFG_ZWAIT_LSB +: 4];
      next_dram_type_select = wr_data[CFG_DTYPE_LSB +: 3];
      next_all_rank_schedule = wr_data[CFG_ALL_RANK_SCHEDULE];
    end
    if (is_wr(OFS_DINIT_TIM)) begin
      next_dram_init_timer_first = wr_data[19:0];
    end
    if (is_wr(OFS_REFRESH)) begin
      next_phy_refresh_period = wr_data[17:0];
    end
    if (is_wr(OFS_SW_CTRL)) begin
      next_software_config_done = wr_data[0];
      next_software_config_done_ack = wr_data[0];
    end
    // quasi-static: only taken while the config window is open
    if (is_wr(OFS_DFI_MISC) && !software_config_done) begin
      next_init_cmpl_en = wr_data[0];
    end
    if (wr_cmd && wr_data[CMD_INIT]) begin
      // new phases restart the done tracking; bits without a
      // phase finish at once
      next_pll_req = wr_data[CMD_PLL];
      next_zcal_req = wr_data[CMD_ZCAL];
      next_dcal_req = wr_data[CMD_DCAL];
      next_pll_done = !wr_data[CMD_PLL];
      next_zcal_done = !wr_data[CMD_ZCAL];
      next_dcal_done = !wr_data[CMD_DCAL];
      next_phy_rst_active = wr_data[CMD_PHYRST];
      next_controller_does_dram_init = wr_data[CMD_CONTROLLER_DOES_DRAM_INIT];
    end else if (dcal_fin || (!dcal_req && pll_fin)) begin
      next_phy_rst_active = 1'b0;
    end
  end

  // done only when every requested phase has finished
  assign next_phy_init_done_flag = pll_done && zcal_done && dcal_done &&
    !pll_busy && !zcal_busy && !dcal_busy && !(wr_cmd && wr_data[CMD_INIT]);
  assign next_dfi_init_complete = next_phy_init_done_flag &&
                                  controller_does_dram_init;

  // ----------------------------------------------------------------
  // controller start-up state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_cstate = cstate;
    next_op_mode = op_mode;
    dram_load = 1'b0;
    unique case (cstate)
      CS_RESET: begin
        if (core_rel) begin
          next_cstate = CS_CONFIG;
        end
      end
      CS_CONFIG: begin
        // start once software closes the window and, if asked,
        // once the PHY reports init complete
        if (software_config_done && software_config_done_ack &&
            (!init_cmpl_en || dfi_init_complete)) begin
          dram_load = 1'b1;
          next_cstate = CS_DRAM_INIT;
        end
      end
      CS_DRAM_INIT: begin
        if (dram_fin) begin
          next_op_mode = OPMODE_NORMAL;
          next_cstate = CS_NORMAL;
        end
      end
      CS_NORMAL: begin
        next_op_mode = OPMODE_NORMAL;
      end
      default: begin
        next_cstate = CS_RESET;
      end
    endcase
    if (!core_rel) begin
      next_cstate = CS_RESET;
      next_op_mode = OPMODE_INIT;
    end
  end

  assign next_ctrl_normal = next_op_mode == OPMODE_NORMAL;
  assign next_core_rst_n_out = next_core_rel;
  assign next_axi_rst_n_out = next_axi_rel;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always_comb begin
    next_reg_rdata = reg_rdata;
    next_mem_sel = mem_sel;
    if (rd_en) begin
      next_mem_sel = train_hit;
      next_reg_rdata = '0;
      unique case (addr)
        OFS_RST_CTRL: next_reg_rdata = {30'h0, axi_rel, core_rel};
        OFS_PHY_CMD: next_reg_rdata = 32'(controller_does_dram_init)
                                      << CMD_CONTROLLER_DOES_DRAM_INIT;
        OFS_PHY_STAT: next_reg_rdata = {27'h0, phy_rst_active, dcal_done,
                                        zcal_done, pll_done,
                                        phy_init_done_flag};
        OFS_PLL_TIM0: next_reg_rdata = {pll_gearshift_time,
                                        pll_powerdown_time};
        OFS_PLL_TIM1: next_reg_rdata = {pll_reset_time, pll_lock_time};
        OFS_PHY_CFG: next_reg_rdata = {19'h0, all_rank_schedule, 1'b0,
                                       dram_type_select, impedance_cal_wait,
                                       2'h0, io_ddr_mode_sel};
        OFS_SW_CTRL: next_reg_rdata = {31'h0, software_config_done};
        OFS_SW_STAT: next_reg_rdata = {31'h0, software_config_done_ack};
        OFS_DFI_MISC: next_reg_rdata = {31'h0, init_cmpl_en};
        OFS_CTRL_STAT: next_reg_rdata = {29'h0, op_mode};
        OFS_DINIT_TIM: next_reg_rdata = {12'h0, dram_init_timer_first};
        OFS_REFRESH: next_reg_rdata = {14'h0, phy_refresh_period};
        default: next_reg_rdata = '0;
      endcase
    end
  end

  assign rd_data = mem_sel ? mem_rdata : reg_rdata;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rel <= 1'b0;
      axi_rel <= 1'b0;
      pll_powerdown_time <= '0;
      pll_gearshift_time <= '0;
      pll_lock_time <= '0;
      pll_reset_time <= '0;
      io_ddr_mode_sel <= IO_DDR_MODE_SEL_RST;
      impedance_cal_wait <= ZWAIT_RST;
      dram_type_select <= DTYPE_RST;
      all_rank_schedule <= 1'b0;
      dram_init_timer_first <= '0;
      phy_refresh_period <= '0;
      software_config_done <= 1'b1;
      software_config_done_ack <= 1'b1;
      init_cmpl_en <= 1'b0;
      controller_does_dram_init <= 1'b0;
      pll_req <= 1'b0;
      zcal_req <= 1'b0;
      dcal_req <= 1'b0;
      pll_done <= 1'b0;
      zcal_done <= 1'b0;
      dcal_done <= 1'b0;
      phy_rst_active <= 1'b0;
      phy_init_done_flag <= 1'b0;
      dfi_init_complete <= 1'b0;
      ctrl_normal <= 1'b0;
      core_rst_n_out <= 1'b0;
      axi_rst_n_out <= 1'b0;
      op_mode <= OPMODE_INIT;
      cstate <= CS_RESET;
      reg_rdata <= '0;
      mem_sel <= 1'b0;
    end else if (ce) begin
      core_rel <= next_core_rel;
      axi_rel <= next_axi_rel;
      pll_powerdown_time <= next_pll_powerdown_time;
      pll_gearshift_time <= next_pll_gearshift_time;
      pll_lock_time <= next_pll_lock_time;
      pll_reset_time <= next_pll_reset_time;
      io_ddr_mode_sel <= next_io_ddr_mode_sel;
      impedance_cal_wait <= next_impedance_cal_wait;
      dram_type_select <= next_dram_type_select;
      all_rank_schedule <= next_all_rank_schedule;
      dram_init_timer_first <= next_dram_init_timer_first;
      phy_refresh_period <= next_phy_refresh_period;
      software_config_done <= next_software_config_done;
      software_config_done_ack <= next_software_config_done_ack;
      init_cmpl_en <= next_init_cmpl_en;
      controller_does_dram_init <= next_controller_does_dram_init;
      pll_req <= next_pll_req;
      zcal_req <= next_zcal_req;
      dcal_req <= next_dcal_req;
      pll_done <= next_pll_done;
      zcal_done <= next_zcal_done;
      dcal_done <= next_dcal_done;
      phy_rst_active <= next_phy_rst_active;
      phy_init_done_flag <= next_phy_init_done_flag;
      dfi_init_complete <= next_dfi_init_complete;
      ctrl_normal <= next_ctrl_normal;
      core_rst_n_out <= next_core_rst_n_out;
      axi_rst_n_out <= next_axi_rst_n_out;
      op_mode <= next_op_mode;
      cstate <= next_cstate;
      reg_rdata <= next_reg_rdata;
      mem_sel <= next_mem_sel;
    end
  end
endmodule // dpi_seq

/* dpi_seq_chk.sv */
// Purpose: port checks of the start-up sequencer
// Assumes: init timer is programmed below 30 cycles in simulation
// Notes: bound into every dpi_seq instance
`timescale 1ns/100ps
module dpi_seq_chk
  import dpi_pkg::*;
#(
  parameter int DCAL_COUNT = 200
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [11:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic core_rst_n_out,
  input wire logic phy_rst_active,
  input wire logic phy_init_done_flag,
  input wire logic dfi_init_complete,
  input wire logic ctrl_normal
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic sw_q, en_q, next_sw_q, next_en_q;
  logic [1:0] sw_age, next_sw_age;
  wire logic wr_ok = wr_en && ce;
  wire logic cmd_wr = wr_ok && addr == OFS_PHY_CMD;
  wire logic sw_wr = wr_ok && addr == OFS_SW_CTRL;
  // ----------------------------------------------------------
  // software view of the done bit and the wait enable
  // ----------------------------------------------------------
  always_comb begin
    next_sw_q = sw_q;
    next_en_q = en_q;
    next_sw_age = sw_age + {1'b0, sw_age != 2'h3};
    if (sw_wr) begin
      next_sw_q = wr_data[0];
      next_sw_age = 2'h0;
    end
    if (wr_ok && addr == OFS_DFI_MISC && !sw_q)
      next_en_q = wr_data[0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_q <= 1'b1;
      en_q <= 1'b0;
      sw_age <= 2'h3;
    end else if (ce) begin
      sw_q <= next_sw_q;
      en_q <= next_en_q;
      sw_age <= next_sw_age;
    end
  end
  sequence s_full_start;
    cmd_wr && wr_data == CMD_FULL_START;
  endsequence
  sequence s_handoff;
    cmd_wr && wr_data == 32'h0004_0001;
  endsequence
  a_start_phy_reset: assert property (s_full_start |-> ##[1:4] phy_rst_active)
    else $error("no phy reset phase after start");
  a_start_clear_done: assert property (s_full_start |-> ##[1:2] !phy_init_done_flag)
    else $error("done flag not cleared by start");
  a_handoff_done: assert property (s_handoff |-> ##[1:6] phy_init_done_flag)
    else $error("done flag late after handoff");
  a_handoff_dfi: assert property (s_handoff |-> ##[1:8] dfi_init_complete)
    else $error("init complete late after handoff");
  a_dfi_needs_done: assert property ($rose(dfi_init_complete) |-> phy_init_done_flag)
    else $error("init complete without done flag");
  a_ack_mirror: assert property (rd_en && ce && addr == OFS_SW_STAT && sw_age == 2'h3
    |=> rd_data[0] == sw_q) else $error("ack differs from done bit");
  a_normal_needs_core: assert property ($rose(ctrl_normal) |-> core_rst_n_out && sw_q)
    else $error("normal mode without release");
  a_normal_waits_dfi: assert property ($rose(ctrl_normal) && en_q |-> dfi_init_complete)
    else $error("normal mode before init complete");
  a_normal_in_time: assert property (sw_wr && wr_data[0] && core_rst_n_out
    && dfi_init_complete && !ctrl_normal |-> ##[1:40] ctrl_normal)
    else $error("normal mode late");
endmodule // dpi_seq_chk
bind dpi_seq dpi_seq_chk #(.DCAL_COUNT(DCAL_COUNT)) i_chk (
  .clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .core_rst_n_out(core_rst_n_out), .phy_rst_active(phy_rst_active),
  .phy_init_done_flag(phy_init_done_flag),
  .dfi_init_complete(dfi_init_complete), .ctrl_normal(ctrl_normal));

/* dpi_timer.sv */
// Purpose: down-counting phase timer with a one-cycle done pulse
// Assumes: load has priority over counting
// Notes: a load of zero finishes one enabled edge after the load is taken
`timescale 1ns/100ps
module dpi_timer #(
  parameter int W = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_busy;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (load) begin
      next_cnt = load_val;
      next_busy = 1'b1;
    end else if (busy) begin
      if (cnt == '0) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule // dpi_timer

/* tb.sv */
// Purpose: register-level bring-up test of the sequencer
// Assumes: delay calibration shortened to 8 cycles
// Notes: dram init timer shortened to 20 cycles
`timescale 1ns/100ps
module tb;
  import dpi_pkg::*;
  localparam int DCAL = 8;
  localparam int TRAS_MAX = 9000;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wr_data = 32'h0, rd_data, d;
  logic core_o, axi_o, phy_rst, done, dfi, normal, ready;
  int miscompares = 0, tests_run = 0, cyc = 0, n;
  time tm;
  always #2.5 clk = ~clk;
  dpi_seq #(.DCAL_COUNT(DCAL)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .core_rst_n_out(core_o), .axi_rst_n_out(axi_o),
    .phy_rst_active(phy_rst), .phy_init_done_flag(done),
    .dfi_init_complete(dfi), .ctrl_normal(normal));
  dpi_sdram_model i_mem (.clk(clk), .rst_n(rst_n), .axi_rst_n_out(axi_o),
    .ctrl_normal(normal), .ready(ready));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, string nm);
    rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic poll(input logic [11:0] a, input logic [31:0] m, e);
    d = e ^ m;
    for (int i = 0; i < 19000 && (d & m) !== e; i++)
      rd(a, d);
    chk("poll", e, d & m);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    ce <= 1'b1;
    rchk(OFS_SW_STAT, 32'h1, "ack_reset");
    rchk(OFS_PHY_STAT, 32'h0, "stat_reset");
    rchk(12'h0f0, 32'h0, "unmapped");
    wr(OFS_DFI_MISC, 32'h1);
    rchk(OFS_DFI_MISC, 32'h0, "en_locked");
    $display("test reset done");
    wr(OFS_PHY_CFG, 32'h0000_1471);
    wr(OFS_PLL_TIM0, 32'h07d0_01f4);
    wr(OFS_PLL_TIM1, 32'h1194_30d4);
    wr(OFS_DINIT_TIM, 32'h0007_a120);
    rchk(OFS_DINIT_TIM, 32'h0007_a120, "dinit0");
    wr(OFS_DINIT_TIM, 32'h0000_0014); // shortened run
    wr(OFS_REFRESH, 32'(TRAS_MAX - 400));
    rchk(OFS_PHY_CFG, 32'h0000_1471, "phy_cfg");
    wr(OFS_RST_CTRL, 32'h3);
    chk("core_rel", 1, core_o);
    chk("axi_rel", 1, axi_o);
    chk("no_traffic", 0, ready);
    $display("test config done");
    wr(OFS_PHY_CMD, CMD_FULL_START);
    tm = $time;
    wr(OFS_TRAIN_BASE + 12'h004, 32'ha5a5_0001);
    rchk(OFS_TRAIN_BASE + 12'h004, 32'ha5a5_0001, "train");
    wr(OFS_TRAIN_BASE + 12'h008, 32'h0003_0d40);
    rchk(OFS_TRAIN_BASE + 12'h008, 32'h0003_0d40, "dinit2");
    poll(OFS_PHY_STAT, 32'h1, 32'h1);
    n = int'(($time - tm) / 5);
    chk("pll_wait", 1, n >= 17000);
    chk("zcal_overlap", 1, n <= 17000 + DCAL + 32);
    wr(OFS_PHY_CMD, 32'h0004_0001);
    poll(OFS_PHY_STAT, 32'h1, 32'h1);
    rchk(OFS_PHY_CMD, 32'h0004_0000, "cmd_rd");
    chk("dfi_done", 1, dfi);
    $display("test phy_init done");
    wr(OFS_SW_CTRL, 32'h0);
    rchk(OFS_SW_STAT, 32'h0, "ack_low");
    wr(OFS_DFI_MISC, 32'h1);
    rchk(OFS_DFI_MISC, 32'h1, "en_set");
    wr(OFS_SW_CTRL, 32'h1);
    poll(OFS_SW_STAT, 32'h1, 32'h1);
    poll(OFS_CTRL_STAT, 32'h7, {29'h0, OPMODE_NORMAL});
    chk("normal", 1, normal);
    @(posedge clk);
    #1 chk("mem_ready", 1, ready);
    $display("test bringup done");
    wr(OFS_RST_CTRL, 32'h2);
    wr(OFS_PHY_CMD, 32'h1);
    wr(OFS_RST_CTRL, 32'h3);
    wr(OFS_SW_CTRL, 32'h0);
    rchk(OFS_CTRL_STAT, {29'h0, OPMODE_INIT}, "held");
    wr(OFS_PHY_CMD, 32'h0004_0001);
    poll(OFS_PHY_STAT, 32'h1, 32'h1);
    rchk(OFS_CTRL_STAT, {29'h0, OPMODE_INIT}, "held_window");
    wr(OFS_SW_CTRL, 32'h1);
    poll(OFS_SW_STAT, 32'h1, 32'h1);
    poll(OFS_CTRL_STAT, 32'h7, {29'h0, OPMODE_NORMAL});
    chk("normal_again", 1, normal);
    $display("test restart done");
    complete_run();
  end
endmodule // tb
